// File: logic/usb_conditioner_config_ctrl.sv
// control, strap latch, speed handling and i2c registers of the conditioner
`timescale 1ns/10ps
`default_nettype none
`include "usb_cond_map.svh"
module usb_conditioner_config_ctrl #(
  parameter int SAMPLE_CYC = `SAMPLE_DLY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_chip_reset_pin_n,
  input wire logic [1:0] i_ac_boost_strap,
  input wire logic [1:0] i_dc_gain_strap,
  input wire logic i_ls_detect,
  input wire logic i_fs_detect,
  input wire logic i_hs_detect,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_connection_detect_out,
  output logic o_comp_enable,
  output logic [2:0] o_ac_boost_level,
  output logic [2:0] o_dc_gain_level,
  output logic o_shutdown,
  output logic o_i2c_mode
);
  localparam int PW = 10; // pins passing the synchroniser

  // every pin goes through two flops before use
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] sync1_q;
  logic [PW-1:0] sync2_q;
  assign pin_raw = {i_chip_reset_pin_n, i_ac_boost_strap, i_dc_gain_strap,
                    i_ls_detect, i_fs_detect, i_hs_detect, i_scl, i_sda};
  always_ff @(posedge i_clk) begin
    sync1_q <= pin_raw;
    sync2_q <= sync1_q;
  end
  logic chip_reset_pin_n_s, ls_s, fs_s, hs_s, scl_s, sda_s;
  logic [1:0] acs_s, dcs_s;
  assign {chip_reset_pin_n_s, acs_s, dcs_s, ls_s, fs_s, hs_s, scl_s, sda_s} = sync2_q;

  // ac strap level to field code
  function automatic usb_cond_pkg::boost_code_t ac_code(input logic [1:0] lvl);
    case (lvl)
      2'h0: ac_code = `AC_LVL0;
      2'h1: ac_code = `AC_LVL1;
      2'h2: ac_code = `AC_LVL2;
      default: ac_code = `AC_LVL3;
    endcase
  endfunction : ac_code

  // tri-level dc strap to field code; unused code reads as mid
  function automatic usb_cond_pkg::boost_code_t dc_code(input logic [1:0] s);
    if (s == `DC_STRAP_LOW) begin
      dc_code = `DC_40MV;
    end else if (s == `DC_STRAP_HIGH) begin
      dc_code = `DC_80MV;
    end else begin
      dc_code = `DC_60MV;
    end
  endfunction : dc_code

  // shutdown follows the synchronised reset pin
  logic shutdown_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shutdown_q <= 1'h1;
    end else begin
      shutdown_q <= ~chip_reset_pin_n_s; // see R8
    end
  end

  // delay from reset release to the i2c mode sample
  logic [15:0] dly_q;
  logic sample_pend_q;
  logic sample_tick;
  assign sample_tick = sample_pend_q && (dly_q == 16'(SAMPLE_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst || shutdown_q) begin
      dly_q <= 16'h0000;
      sample_pend_q <= ~i_rst; // armed again by every reset pulse
    end else if (sample_tick) begin
      sample_pend_q <= 1'h0;
    end else if (sample_pend_q) begin
      dly_q <= dly_q + 16'h0001;
    end
  end

  // i2c mode: both lines high at the sample point
  logic i2c_mode_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || shutdown_q) begin
      i2c_mode_q <= 1'h0;
    end else if (sample_tick) begin
      i2c_mode_q <= scl_s & sda_s; // see R9
    end
  end

  // i2c line edges, read only from the second sync flop onward
  logic scl_p_q, sda_p_q;
  always_ff @(posedge i_clk) begin
    scl_p_q <= scl_s;
    sda_p_q <= sda_s;
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // i2c target state
  usb_cond_pkg::i2c_state_e st_q;
  logic [3:0] cnt_q; // bits taken in the current byte
  logic [7:0] sr_q; // receive shift
  logic [7:0] tx_q; // transmit shift
  logic [7:0] ptr_q; // register pointer, auto increments
  logic ack_q; // inside an acknowledge slot
  logic sda_oe_n_q;
  logic wr_stb; // write of sr_q to ptr_q
  logic addr_hit;
  assign addr_hit = (sr_q[7:1] == `I2C_TARGET_ADDR);
  assign wr_stb = scl_fall && !ack_q && (st_q == usb_cond_pkg::ST_WDATA) && (cnt_q == 4'h8);

  // register read mux, reserved bits read zero
  logic [7:0] rd_data;
  logic [2:0] ac_q, dc_q;
  logic hold_q;
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q == `OFF_AC_BOOST) begin
      rd_data[`AC_FIELD_HI:`AC_FIELD_LO] = ac_q;
    end else if (ptr_q == `OFF_CFG_HOLD) begin
      rd_data[`HOLD_BIT] = hold_q;
    end else if (ptr_q == `OFF_DC_GAIN) begin
      rd_data[`DC_FIELD_HI:`DC_FIELD_LO] = dc_q;
    end
  end

  // byte engine: shift on scl rise, drive on scl fall
  always_ff @(posedge i_clk) begin
    if (i_rst || !i2c_mode_q || stop_c) begin
      st_q <= usb_cond_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      ack_q <= 1'h0;
      sda_oe_n_q <= 1'h1;
      if (i_rst) begin
        sr_q <= 8'h00;
        tx_q <= 8'h00;
        ptr_q <= 8'h00;
      end
    end else if (start_c) begin
      st_q <= usb_cond_pkg::ST_ADDR; // repeated start keeps the pointer
      cnt_q <= 4'h0;
      ack_q <= 1'h0;
      sda_oe_n_q <= 1'h1;
    end else if (scl_rise && !ack_q) begin
      case (st_q)
        usb_cond_pkg::ST_ADDR, usb_cond_pkg::ST_PTR, usb_cond_pkg::ST_WDATA: begin
          sr_q <= {sr_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end
        usb_cond_pkg::ST_RDATA: begin
          if (cnt_q == 4'h8) begin
            // master ack: reload next byte, nack: go quiet
            if (sda_s) begin
              st_q <= usb_cond_pkg::ST_IDLE;
            end else begin
              ack_q <= 1'h1;
              ptr_q <= ptr_q + 8'h01;
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          cnt_q <= 4'h0;
        end
      endcase
    end else if (scl_fall) begin
      if (ack_q) begin
        // end of ack slot
        ack_q <= 1'h0;
        cnt_q <= 4'h0;
        if (st_q == usb_cond_pkg::ST_RDATA) begin
          tx_q <= rd_data;
          sda_oe_n_q <= rd_data[7];
        end else begin
          sda_oe_n_q <= 1'h1;
        end
      end else if (cnt_q == 4'h8) begin
        case (st_q)
          usb_cond_pkg::ST_ADDR: begin
            if (addr_hit) begin
              ack_q <= 1'h1;
              sda_oe_n_q <= 1'h0; // see R10
              st_q <= sr_q[0] ? usb_cond_pkg::ST_RDATA : usb_cond_pkg::ST_PTR;
            end else begin
              st_q <= usb_cond_pkg::ST_IDLE;
            end
          end
          usb_cond_pkg::ST_PTR: begin
            ptr_q <= sr_q;
            ack_q <= 1'h1;
            sda_oe_n_q <= 1'h0;
            st_q <= usb_cond_pkg::ST_WDATA;
          end
          usb_cond_pkg::ST_WDATA: begin
            ptr_q <= ptr_q + 8'h01;
            ack_q <= 1'h1;
            sda_oe_n_q <= 1'h0;
          end
          default: begin
            sda_oe_n_q <= 1'h1; // release for master ack bit
          end
        endcase
      end else if (st_q == usb_cond_pkg::ST_RDATA) begin
        tx_q <= {tx_q[6:0], 1'h0};
        sda_oe_n_q <= tx_q[6];
      end
    end
  end

  // boost fields: strap while in reset, i2c writes afterwards
  always_ff @(posedge i_clk) begin
    if (i_rst || shutdown_q) begin
      ac_q <= ac_code(acs_s); // see R3 R13 R17
      dc_q <= dc_code(dcs_s); // see R4 R16 R17
    end else if (wr_stb && ptr_q == `OFF_AC_BOOST) begin
      ac_q <= sr_q[`AC_FIELD_HI:`AC_FIELD_LO]; // see R13
    end else if (wr_stb && ptr_q == `OFF_DC_GAIN) begin
      dc_q <= sr_q[`DC_FIELD_HI:`DC_FIELD_LO]; // see R16
    end
  end

  // hold bit stops compensation until released
  always_ff @(posedge i_clk) begin
    if (i_rst || shutdown_q) begin
      hold_q <= `HOLD_RESET; // see R14
    end else if (sample_tick && !(scl_s && sda_s)) begin
      hold_q <= 1'h0; // see R15
    end else if (wr_stb && ptr_q == `OFF_CFG_HOLD) begin
      hold_q <= sr_q[`HOLD_BIT]; // see R14 R15
    end
  end

  // speed handling; hs wins if analog flags overlap
  logic cd_q, comp_q, sda_out_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || shutdown_q) begin
      cd_q <= 1'h0; // see R8
      comp_q <= 1'h0; // see R8
    end else begin
      cd_q <= ls_s | fs_s | hs_s; // see R5 R6 R7 R18
      comp_q <= hs_s & ~hold_q; // see R5 R6 R7
    end
  end
  always_ff @(posedge i_clk) begin
    sda_out_q <= 1'h0; // open drain: only ever pulls low
  end

  assign o_sda_out = sda_out_q;
  assign o_sda_oe_n = sda_oe_n_q;
  assign o_connection_detect_out = cd_q;
  assign o_comp_enable = comp_q;
  assign o_ac_boost_level = ac_q;
  assign o_dc_gain_level = dc_q;
  assign o_shutdown = shutdown_q;
  assign o_i2c_mode = i2c_mode_q;

  // checks
  a_shut_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // see R8
    shutdown_q |=> !cd_q && !comp_q) else $error("output active in shutdown");
  a_hs_comp_on: assert property (@(posedge i_clk) disable iff (i_rst) // see R7
    !shutdown_q && hs_s && !hold_q ##1 !shutdown_q |-> comp_q && cd_q)
    else $error("hs without compensation");
  a_fsls_no_comp: assert property (@(posedge i_clk) disable iff (i_rst) // see R5 R6
    !shutdown_q && !hs_s && (ls_s || fs_s) |=> !comp_q && (cd_q || shutdown_q))
    else $error("ls fs handling wrong");
  a_idle_cd_low: assert property (@(posedge i_clk) disable iff (i_rst) // see R18
    !(ls_s || fs_s || hs_s) |=> !cd_q) else $error("detect high with no link");
  a_ac_strap_map: assert property (@(posedge i_clk) disable iff (i_rst) // see R3 R13
    shutdown_q && acs_s == 2'h2 |=> ac_q == `AC_LVL2) else $error("ac strap decode");
  a_dc_strap_map: assert property (@(posedge i_clk) disable iff (i_rst) // see R4 R16
    shutdown_q && dcs_s == `DC_STRAP_LOW |=> dc_q == `DC_40MV) else $error("dc strap decode");
  a_strap_frozen: assert property (@(posedge i_clk) disable iff (i_rst) // see R17
    !shutdown_q && !i2c_mode_q ##1 !shutdown_q |-> $stable(ac_q) && $stable(dc_q))
    else $error("strap followed after reset");
  a_i2c_sample: assert property (@(posedge i_clk) disable iff (i_rst) // see R9
    $rose(i2c_mode_q) |-> $past(sample_tick) && $past(scl_s) && $past(sda_s))
    else $error("i2c mode without sample");
  a_hold_auto: assert property (@(posedge i_clk) disable iff (i_rst) // see R15
    !shutdown_q && sample_tick && !(scl_s && sda_s) && chip_reset_pin_n_s |=> ##1 !hold_q && !i2c_mode_q)
    else $error("hold not cleared");
  a_hold_reset: assert property (@(posedge i_clk) // see R14
    i_rst |=> hold_q) else $error("hold reset value");
  a_addr_ack: assert property (@(posedge i_clk) disable iff (i_rst) // see R10
    i2c_mode_q && !stop_c && !start_c && scl_fall && !ack_q && st_q == usb_cond_pkg::ST_ADDR
    && cnt_q == 4'h8 && addr_hit |=> !sda_oe_n_q && ack_q) else $error("no address ack");
endmodule : usb_conditioner_config_ctrl
`default_nettype wire

// File: logic/usb_cond_map.svh
// constants of the usb conditioner control block
// Operation
// R1 - controller holds reset low at least 20 us
// R2 - reset held until supply stable 100 us
// R3 - ac boost strap selects one of four levels
// R4 - dc strap low/mid/high gives 40/60/80 mV
// R5 - low speed: no compensation, detect high
// R6 - full speed: no compensation, detect high
// R7 - high speed: compensate with boosts, detect high
// R8 - reset low means shutdown, no compensation
// R9 - i2c enabled if scl, sda high after reset
// R10 - i2c target 0x2C reads and writes registers
// R11 - controller pulses hold bit after boost change
// R12 - controller preserves reserved fields via read-modify-write
// R13 - ac boost field bits 6:4, thermometer code
// R14 - hold bit 0 at 0x03, resets to one
// R15 - hold kept under i2c, else auto cleared
// R16 - dc_gain_strap field bits 2:0 at 0x0E
// R17 - straps latched only during reset
// R18 - no connection and running: detect low
`ifndef USB_COND_MAP_SVH
`define USB_COND_MAP_SVH
`define I2C_TARGET_ADDR 7'h2C
`define OFF_AC_BOOST 8'h01
`define OFF_CFG_HOLD 8'h03
`define OFF_DC_GAIN 8'h0E
`define AC_FIELD_HI 6
`define AC_FIELD_LO 4
`define HOLD_BIT 0
`define DC_FIELD_HI 2
`define DC_FIELD_LO 0
`define AC_LVL0 3'h0
`define AC_LVL1 3'h1
`define AC_LVL2 3'h3
`define AC_LVL3 3'h7
`define DC_40MV 3'h3
`define DC_60MV 3'h5
`define DC_80MV 3'h7
`define DC_STRAP_LOW 2'h0
`define DC_STRAP_MID 2'h1
`define DC_STRAP_HIGH 2'h3
`define HOLD_RESET 1'h1
`define CLK_MHZ 125
`define SAMPLE_DLY_NS 1000
`define SAMPLE_DLY_CYC ((`SAMPLE_DLY_NS * `CLK_MHZ + 999) / 1000)
`endif

// File: logic/usb_cond_pkg.sv
// types of the usb conditioner control block
package usb_cond_pkg;
  // i2c target byte phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA
  } i2c_state_e;
  typedef logic [2:0] boost_code_t;
endpackage : usb_cond_pkg

// File: sim/usb_cond_host_model.sv
// i2c controller model standing for the system microcontroller
`timescale 1ns/10ps
`default_nettype none
module usb_cond_host_model (
  input wire logic i_clk,
  input wire logic i_sda_wire,
  output logic o_scl,
  output logic o_sda_rel
);
  // half bit time, scaled well above 100 kHz to keep the run short
  localparam int HALF = 40;
  // both lines start released, the pull-up holds them high
  initial begin
    o_scl = 1'h1;
    o_sda_rel = 1'h1;
  end
  // one half bit; lines move 1 ns after the edge
  task automatic hp();
    repeat (HALF) @(posedge i_clk);
    #1;
  endtask : hp
  // data set while scl low, wire sampled at the end of scl high
  task automatic bit_io(input logic b, output logic s);
    o_sda_rel = b;
    hp();
    o_scl = 1'h1;
    hp();
    s = i_sda_wire;
    o_scl = 1'h0;
    // hold time, so sda never moves in the cycle scl falls
    repeat (8) @(posedge i_clk);
    #1;
  endtask : bit_io
  // start, also usable as a repeated start
  task automatic start();
    o_sda_rel = 1'h1;
    hp();
    o_scl = 1'h1;
    hp();
    o_sda_rel = 1'h0;
    hp();
    o_scl = 1'h0;
    hp();
  endtask : start
  // stop: sda rises while scl high
  task automatic stop();
    o_sda_rel = 1'h0;
    hp();
    o_scl = 1'h1;
    hp();
    o_sda_rel = 1'h1;
    hp();
  endtask : stop
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ack_in, ack);
  endtask : xfer
  // sda level offered while the reset pin is released
  task automatic hold_sda(input logic v);
    o_sda_rel = v;
  endtask : hold_sda
endmodule : usb_cond_host_model
`default_nettype wire

// File: sim/usb_conditioner_config_ctrl_bench.sv
// self-checking bench of the conditioner control block
`timescale 1ns/10ps
`default_nettype none
`include "usb_cond_map.svh"
module usb_conditioner_config_ctrl_bench;
  logic i_clk = 1'h0, i_rst = 1'h1, pin_n = 1'h0, ls = 1'h0, fs = 1'h0, hs = 1'h0;
  logic [1:0] ac_s = 2'h0, dc_s = 2'h0;
  logic scl, sda_rel, sda_w, sda_out, sda_oe_n, cd, comp, shut, i2c;
  logic [2:0] ac_lvl, dc_lvl;
  logic [7:0] rd_q;
  logic nak; // acknowledge level seen by the host
  int error_cnt = 0, checked = 0;
  // strap codes per loop pass and their expected fields, then the ls/fs/hs speed patterns
  logic [1:0] dc_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [2:0] ac_exp [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [2:0] dc_exp [4] = '{3'h3, 3'h5, 3'h7, 3'h5};
  logic [2:0] spd [4] = '{3'h4, 3'h2, 3'h0, 3'h1};
  // 8 ns clock
  always #4 i_clk = ~i_clk;
  // open-drain wire with pull-up: low if either side pulls
  assign sda_w = sda_rel & (sda_oe_n ? 1'h1 : sda_out);
  usb_cond_host_model u_host (.i_clk(i_clk), .i_sda_wire(sda_w), .o_scl(scl),
    .o_sda_rel(sda_rel));
  usb_conditioner_config_ctrl #(.SAMPLE_CYC(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_chip_reset_pin_n(pin_n), .i_ac_boost_strap(ac_s), .i_dc_gain_strap(dc_s),
    .i_ls_detect(ls), .i_fs_detect(fs), .i_hs_detect(hs), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_connection_detect_out(cd),
    .o_comp_enable(comp), .o_ac_boost_level(ac_lvl), .o_dc_gain_level(dc_lvl),
    .o_shutdown(shut), .o_i2c_mode(i2c));
  // counted compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  // address byte, acked by the target
  task automatic addr(input logic rnw);
    logic [7:0] rx;
    logic ack;
    u_host.start();
    u_host.xfer({`I2C_TARGET_ADDR, rnw}, 1'h1, rx, ack);
    chk(8'(ack), 8'h00);
  endtask : addr
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] rx;
    logic a1, a2;
    addr(1'h0);
    u_host.xfer(ptr, 1'h1, rx, a1);
    u_host.xfer(d, 1'h1, rx, a2);
    u_host.stop();
    chk(8'({a1, a2}), 8'h00);
  endtask : wr
  // single byte read, ended by nack
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic ack;
    addr(1'h0);
    u_host.xfer(ptr, 1'h1, rd_q, ack);
    addr(1'h1);
    u_host.xfer(8'hFF, 1'h1, rd_q, ack);
    u_host.stop();
    chk(rd_q, exp);
  endtask : rd
  // reset pin held low 20 us with new straps, then released
  task automatic pin_reset(input logic [1:0] a, input logic [1:0] d, input logic s);
    pin_n = 1'h0;
    ac_s = a;
    dc_s = d;
    u_host.hold_sda(s);
    cyc(2500);
    chk(8'({shut, cd, comp}), 8'h04);
    pin_n = 1'h1;
    cyc(14);
    u_host.hold_sda(1'h1);
  endtask : pin_reset
  // watchdog against a hang
  initial begin
    cyc(90000);
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    hs = 1'h1;
    cyc(6);
    i_rst = 1'h0;
    cyc(12500);
    for (int k = 0; k < 4; k++) begin
      pin_reset(2'(k), dc_tab[k], k != 3);
      chk(8'({ac_lvl, dc_lvl}), 8'({ac_exp[k], dc_exp[k]}));
      chk(8'(i2c), 8'(k != 3));
    end
    chk(8'(comp), 8'h01);
    ac_s = 2'h0;
    dc_s = 2'h0;
    cyc(8);
    chk(8'({ac_lvl, dc_lvl}), 8'h3D);
    $display("test straps done");
    pin_reset(2'h2, 2'h1, 1'h1);
    for (int m = 0; m < 4; m++) begin
      {ls, fs, hs} = spd[m];
      cyc(6);
      chk(8'({cd, comp}), 8'({m != 2, 1'h0}));
    end
    $display("test speed done");
    rd(`OFF_CFG_HOLD, 8'h01);
    wr(`OFF_CFG_HOLD, 8'h00);
    chk(8'(comp), 8'h01);
    rd(`OFF_AC_BOOST, 8'h30);
    wr(`OFF_AC_BOOST, 8'h70);
    wr(`OFF_DC_GAIN, 8'h07);
    wr(`OFF_CFG_HOLD, 8'h01);
    chk(8'(comp), 8'h00);
    wr(`OFF_CFG_HOLD, 8'h00);
    chk(8'({comp, ac_lvl, dc_lvl}), 8'h7F);
    rd(`OFF_DC_GAIN, 8'h07);
    // two-byte read across the pointer increment, reserved byte first
    addr(1'h0);
    u_host.xfer(8'h0D, 1'h1, rd_q, nak);
    addr(1'h1);
    u_host.xfer(8'hFF, 1'h0, rd_q, nak);
    chk(rd_q, 8'h00);
    u_host.xfer(8'hFF, 1'h1, rd_q, nak);
    u_host.stop();
    chk(rd_q, 8'h07);
    // a foreign address is left unanswered
    u_host.start();
    u_host.xfer(8'h5A, 1'h1, rd_q, nak);
    u_host.stop();
    chk(8'(nak), 8'h01);
    $display("test i2c done");
    conclude();
  end
endmodule : usb_conditioner_config_ctrl_bench
`default_nettype wire
